// ### design/afe_signal_path_mode_control.sv
// per-slot signal path mode registers, decode and sample sequencing
//
// Behaviour
// - gain codes 00/01 unity, 10 gives 0.7
// - slot bit turns integrator into buffer
// - 0xada5 normal, 0xae65 skips band-pass filter
// - 0xb065 skips filter and integrator
// - global bit gates integrator-as-buffer
// - pulse connect pulses input, not led
// - each slot runs its own mode
// - samples go to fifo and data registers
// - float: precondition, float, integrate while floating, reconnect in negative phase
// - float mode bypasses filter, keeps integrator
// - float charge dump in negative phase
`timescale 1ns/1ps
`default_nettype none
module afe_signal_path_mode_control
    import afe_path_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic sample_start,
    input wire logic sample_slot,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data,
    output logic buf_gain_low,
    output logic int_as_buf,
    output logic bpf_bypass,
    output logic int_bypass,
    output logic led_pulse,
    output logic pd_connect,
    output logic int_active,
    output logic int_negative,
    output logic fifo_push,
    output logic [15:0] fifo_data
);
    // per-slot storage, index 0 is slot a
    logic [15:0] setup_q [NUM_SLOTS];
    logic [15:0] path_q [NUM_SLOTS];
    logic [15:0] data_q [NUM_SLOTS];
    // shared registers
    logic [15:0] global_q;       // integrator buffer global enable
    logic [15:0] led_sel_q;      // led selection fields of both slots
    logic [15:0] float_ctrl_q;   // per-slot float enables
    logic [15:0] float_time_q;   // float time in cycles
    logic [15:0] pulse_width_q;  // pulse width in cycles
    logic [15:0] phase_len_q;    // integration phase length in cycles
    logic [15:0] rdata_q;        // read answer
    logic active_slot_q;         // slot of the sample under way
    // registered path controls
    logic gain_low_q, as_buf_q, bpf_byp_q, int_byp_q;
    logic led_q, pd_q, int_on_q, int_neg_q;
    logic push_q;
    logic [15:0] push_data_q;

    // address decode
    wire logic hit_led = (reg_addr == OFF_LED_SELECT);
    wire logic hit_setup_a = (reg_addr == OFF_SLOT_A_SETUP);
    wire logic hit_path_a = (reg_addr == OFF_SLOT_A_PATH);
    wire logic hit_setup_b = (reg_addr == OFF_SLOT_B_SETUP);
    wire logic hit_path_b = (reg_addr == OFF_SLOT_B_PATH);
    wire logic hit_global = (reg_addr == OFF_GLOBAL_EN);
    wire logic hit_float = (reg_addr == OFF_FLOAT_CTRL);
    wire logic hit_ftime = (reg_addr == OFF_FLOAT_TIME);
    wire logic hit_pwidth = (reg_addr == OFF_PULSE_WIDTH);
    wire logic hit_phase = (reg_addr == OFF_PHASE_LEN);
    wire logic hit_status = (reg_addr == OFF_STATUS);
    wire logic hit_data_a = (reg_addr == OFF_DATA_A);
    wire logic hit_data_b = (reg_addr == OFF_DATA_B);
    wire logic [NUM_SLOTS-1:0] hit_setup = {hit_setup_b, hit_setup_a};
    wire logic [NUM_SLOTS-1:0] hit_path = {hit_path_b, hit_path_a};

    // sequencer outputs
    logic seq_led, seq_pd, seq_int, seq_neg, seq_busy;

    // slot chosen for this sample: new slot at start, else held one
    wire logic cur_slot = sample_start ? sample_slot : active_slot_q;

    // settings of the current slot toward the decoder
    slot_cfg_if cfg_bus ();
    assign cfg_bus.setup = setup_q[cur_slot];
    assign cfg_bus.path = path_q[cur_slot];
    // slot b uses bits 3:2, slot a bits 1:0
    assign cfg_bus.led_sel = cur_slot ? led_sel_q[3:2] : led_sel_q[1:0];
    assign cfg_bus.glob_en = global_q[GLOBAL_EN_BIT];
    assign cfg_bus.float_en = float_ctrl_q[cur_slot];

    // path decoder
    slot_path_decode u_decode (
        .cfg (cfg_bus)
    );

    // timing of one sample
    meas_sequencer u_seq (
        .sys_clk (sys_clk),
        .rst_b (rst_b),
        .start (sample_start),
        .float_mode (cfg_bus.float_mode),
        .pulse_conn (cfg_bus.pulse_conn),
        .pulse_cyc (pulse_width_q),
        .float_cyc (float_time_q),
        .phase_cyc (phase_len_q),
        .led_on (seq_led),
        .pd_on (seq_pd),
        .int_on (seq_int),
        .int_neg (seq_neg),
        .busy (seq_busy)
    );

    // status word: busy, active slot, current slot mode flags
    wire logic [15:0] status_word = {10'h000, cfg_bus.float_mode, cfg_bus.pulse_conn,
                                     cfg_bus.int_bypass, cfg_bus.bpf_bypass,
                                     active_slot_q, seq_busy};

    // read mux; unmapped addresses read zero
    wire logic [15:0] rd_mux =
        hit_led ? led_sel_q :
        hit_setup_a ? setup_q[0] :
        hit_path_a ? path_q[0] :
        hit_setup_b ? setup_q[1] :
        hit_path_b ? path_q[1] :
        hit_global ? global_q :
        hit_float ? float_ctrl_q :
        hit_ftime ? float_time_q :
        hit_pwidth ? pulse_width_q :
        hit_phase ? phase_len_q :
        hit_status ? status_word :
        hit_data_a ? data_q[0] :
        hit_data_b ? data_q[1] : 16'h0000;

    // per-slot setup, path and result registers
    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
            // setup word, held until rewritten
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    setup_q[s] <= RST_SETUP;
                end else if (reg_wr && hit_setup[s]) begin
                    setup_q[s] <= reg_wdata;
                end
            end
            // path connection word, held until rewritten
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    path_q[s] <= RST_PATH;
                end else if (reg_wr && hit_path[s]) begin
                    path_q[s] <= reg_wdata;
                end
            end
            // latest result of this slot, readable directly
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    data_q[s] <= 16'h0000;
                end else if (adc_valid && (active_slot_q == 1'(s))) begin
                    data_q[s] <= adc_data;
                end
            end
        end
    endgenerate

    // shared control registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_q <= RST_GLOBAL;
            led_sel_q <= RST_LED_SELECT;
            float_ctrl_q <= RST_FLOAT_CTRL;
        end else if (reg_wr) begin
            if (hit_global) global_q <= reg_wdata;
            if (hit_led) led_sel_q <= reg_wdata;
            if (hit_float) float_ctrl_q <= reg_wdata;
        end
    end

    // timing registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            float_time_q <= FLOAT_MIN_CYC;
            pulse_width_q <= PULSE_DEF_CYC;
            phase_len_q <= PHASE_DEF_CYC;
        end else if (reg_wr) begin
            if (hit_ftime) float_time_q <= reg_wdata;
            if (hit_pwidth) pulse_width_q <= reg_wdata;
            if (hit_phase) phase_len_q <= reg_wdata;
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // remember which slot the running sample belongs to
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            active_slot_q <= 1'b0;
        end else begin
            active_slot_q <= cur_slot;
        end
    end

    // decoded path controls, re-applied every cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gain_low_q <= 1'b0;
            as_buf_q <= 1'b0;
            bpf_byp_q <= 1'b0;
            int_byp_q <= 1'b0;
        end else begin
            gain_low_q <= cfg_bus.gain_low;
            as_buf_q <= cfg_bus.int_as_buf;
            bpf_byp_q <= cfg_bus.bpf_bypass;
            int_byp_q <= cfg_bus.int_bypass;
        end
    end

    // sequencer switch controls
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            led_q <= 1'b0;
            pd_q <= 1'b0;
            int_on_q <= 1'b0;
            int_neg_q <= 1'b0;
        end else begin
            led_q <= seq_led;
            pd_q <= seq_pd;
            int_on_q <= seq_int;
            int_neg_q <= seq_neg;
        end
    end

    // every result also goes toward the fifo
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            push_q <= 1'b0;
            push_data_q <= 16'h0000;
        end else begin
            push_q <= adc_valid;
            push_data_q <= adc_valid ? adc_data : push_data_q;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign buf_gain_low = gain_low_q;
    assign int_as_buf = as_buf_q;
    assign bpf_bypass = bpf_byp_q;
    assign int_bypass = int_byp_q;
    assign led_pulse = led_q;
    assign pd_connect = pd_q;
    assign int_active = int_on_q;
    assign int_negative = int_neg_q;
    assign fifo_push = push_q;
    assign fifo_data = push_data_q;
endmodule // afe_signal_path_mode_control
`default_nettype wire

// ### design/afe_path_pkg.sv
// constants for the signal path mode control bank
package afe_path_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_SLOTS = 2;
    // register offsets
    localparam logic [7:0] OFF_LED_SELECT = 8'h14;
    localparam logic [7:0] OFF_SLOT_A_SETUP = 8'h42;
    localparam logic [7:0] OFF_SLOT_A_PATH = 8'h43;
    localparam logic [7:0] OFF_SLOT_B_SETUP = 8'h44;
    localparam logic [7:0] OFF_SLOT_B_PATH = 8'h45;
    localparam logic [7:0] OFF_GLOBAL_EN = 8'h58;
    localparam logic [7:0] OFF_FLOAT_CTRL = 8'h5a;
    localparam logic [7:0] OFF_FLOAT_TIME = 8'h5b;
    localparam logic [7:0] OFF_PULSE_WIDTH = 8'h5c;
    localparam logic [7:0] OFF_PHASE_LEN = 8'h5d;
    localparam logic [7:0] OFF_STATUS = 8'h60;
    localparam logic [7:0] OFF_DATA_A = 8'h61;
    localparam logic [7:0] OFF_DATA_B = 8'h62;
    // setup and global enable word fields
    localparam int MODE_LSB = 10;
    localparam int MODE_MSB = 15;
    localparam int GAIN_LSB = 8;
    localparam int GAIN_MSB = 9;
    localparam int AS_BUF_BIT = 7;
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [1:0] GAIN_CODE_LOW = 2'h2;
    // path connection codes
    localparam logic [15:0] PATH_NORMAL = 16'hada5;
    localparam logic [15:0] PATH_NO_BPF = 16'hae65;
    localparam logic [15:0] PATH_NO_BPF_INT = 16'hb065;
    // reset values (normal mode settings)
    localparam logic [15:0] RST_SETUP = 16'h1c00;
    localparam logic [15:0] RST_PATH = 16'hada5;
    localparam logic [15:0] RST_GLOBAL = 16'h0000;
    localparam logic [15:0] RST_LED_SELECT = 16'h0005;
    localparam logic [15:0] RST_FLOAT_CTRL = 16'h0000;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FLOAT_MIN_NS = 4000;
    localparam int PRECOND_NS = 2000;
    localparam int PULSE_DEF_NS = 2000;
    localparam int PHASE_DEF_NS = 1000;
    localparam logic [15:0] FLOAT_MIN_CYC =
        16'((FLOAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] PRECOND_CYC = 16'(PRECOND_NS / CLK_PERIOD_NS);
    localparam logic [15:0] PULSE_DEF_CYC = 16'(PULSE_DEF_NS / CLK_PERIOD_NS);
    localparam logic [15:0] PHASE_DEF_CYC = 16'(PHASE_DEF_NS / CLK_PERIOD_NS);
    // measurement sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_PULSE = 3'b001,
        SEQ_PRECOND = 3'b010,
        SEQ_FLOAT = 3'b011,
        SEQ_POS = 3'b100,
        SEQ_NEG = 3'b101
    } seq_state_t;
endpackage

// ### design/slot_cfg_if.sv
// carries one slot's settings to the path decoder and its decoded controls back
`timescale 1ns/1ps
`default_nettype none
interface slot_cfg_if;
    logic [15:0] setup;      // integrator setup word
    logic [15:0] path;       // path connection word
    logic [1:0] led_sel;     // led selection field of the slot
    logic glob_en;           // integrator-as-buffer global enable
    logic float_en;          // float mode enable of the slot
    logic gain_low;          // buffer gain 0.7
    logic int_as_buf;        // integrator used as buffer
    logic bpf_bypass;        // band-pass filter bypassed
    logic int_bypass;        // integrator bypassed
    logic pulse_conn;        // pulse connect mode
    logic float_mode;        // float mode
    modport cfg (output setup, path, led_sel, glob_en, float_en,
                 input gain_low, int_as_buf, bpf_bypass, int_bypass, pulse_conn, float_mode);
    modport dec (input setup, path, led_sel, glob_en, float_en,
                 output gain_low, int_as_buf, bpf_bypass, int_bypass, pulse_conn, float_mode);
endinterface
`default_nettype wire

// ### design/slot_path_decode.sv
// decodes one slot's setup and path words into signal path controls
`timescale 1ns/1ps
`default_nettype none
module slot_path_decode
    import afe_path_pkg::*;
(
    slot_cfg_if.dec cfg
);
    // gain field and path code compares
    wire logic [1:0] gain_code = cfg.setup[GAIN_MSB:GAIN_LSB];
    wire logic path_no_bpf = (cfg.path == PATH_NO_BPF);
    wire logic path_no_both = (cfg.path == PATH_NO_BPF_INT);

    // codes 00, 01 and 11 leave unity gain
    assign cfg.gain_low = (gain_code == GAIN_CODE_LOW);
    // buffer only when the slot asks and the global gate allows
    assign cfg.int_as_buf = cfg.setup[AS_BUF_BIT] & cfg.glob_en;
    // float mode forces the filter out of the path
    assign cfg.bpf_bypass = path_no_bpf | path_no_both | cfg.float_en;
    // float mode always keeps the integrator
    assign cfg.int_bypass = path_no_both & ~cfg.float_en;
    // cleared led field turns the led pulse into an input pulse
    assign cfg.pulse_conn = (cfg.led_sel == 2'h0) & ~cfg.float_en;
    assign cfg.float_mode = cfg.float_en;
endmodule // slot_path_decode
`default_nettype wire

// ### design/meas_sequencer.sv
// steps one sample through pulse, pulse connect or float timing
`timescale 1ns/1ps
`default_nettype none
module meas_sequencer
    import afe_path_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic float_mode,
    input wire logic pulse_conn,
    input wire logic [15:0] pulse_cyc,
    input wire logic [15:0] float_cyc,
    input wire logic [15:0] phase_cyc,
    output logic led_on,
    output logic pd_on,
    output logic int_on,
    output logic int_neg,
    output logic busy
);
    seq_state_t state_q, state_d; // current step
    logic [15:0] cnt_q, cnt_d;    // cycles left in the step
    logic float_q;                // float run latched at start
    logic conn_q;                 // pulse connect latched at start
    wire logic cnt_last = (cnt_q <= 16'h0001);
    // float time never shorter than the minimum
    wire logic [15:0] float_len = (float_cyc < FLOAT_MIN_CYC) ? FLOAT_MIN_CYC : float_cyc;

    // next step and its length
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q - 16'h0001;
        unique case (state_q)
            SEQ_IDLE: begin
                cnt_d = cnt_q;
                if (start && float_mode) begin
                    state_d = SEQ_PRECOND;
                    cnt_d = PRECOND_CYC;
                end else if (start) begin
                    state_d = SEQ_PULSE;
                    cnt_d = pulse_cyc;
                end
            end
            SEQ_PULSE: if (cnt_last) state_d = SEQ_IDLE;
            SEQ_PRECOND: if (cnt_last) begin
                state_d = SEQ_FLOAT;
                cnt_d = float_len;
            end
            SEQ_FLOAT: if (cnt_last) begin
                state_d = SEQ_POS;
                cnt_d = phase_cyc;
            end
            SEQ_POS: if (cnt_last) begin
                state_d = SEQ_NEG;
                cnt_d = phase_cyc;
            end
            SEQ_NEG: if (cnt_last) state_d = SEQ_IDLE;
            default: state_d = SEQ_IDLE;
        endcase
    end

    // state, counter and mode latches
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SEQ_IDLE;
            cnt_q <= 16'h0000;
            float_q <= 1'b0;
            conn_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (state_q == SEQ_IDLE) begin
                float_q <= float_mode;
                conn_q <= pulse_conn;
            end
        end
    end

    // led fires only in a plain pulsed sample
    assign led_on = (state_q == SEQ_PULSE) & ~conn_q;
    // input pulsed in pulse connect, held in normal, floated between
    // idle connection stays open in pulse connect so only the pulse reaches the input
    assign pd_on = (state_q == SEQ_PULSE) | (state_q == SEQ_PRECOND) | (state_q == SEQ_NEG)
                 | ((state_q == SEQ_IDLE) & ~float_q & ~conn_q);
    assign int_on = (state_q == SEQ_POS) | (state_q == SEQ_NEG);
    // charge dump lands in the negative phase only
    assign int_neg = (state_q == SEQ_NEG);
    assign busy = (state_q != SEQ_IDLE);
endmodule // meas_sequencer
`default_nettype wire

// ### test/afe_sensor_model.sv
// behavioural sensor front and converter result source for the far side
`timescale 1ns/1ps
`default_nettype none
module afe_sensor_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic trig,
    input wire logic [15:0] level,
    output logic adc_valid,
    output logic [15:0] adc_data
);
    // one result strobe per trigger, data scrambled whenever not valid
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_valid <= 1'b0;
            adc_data <= 16'h0000;
        end else if (trig) begin
            adc_valid <= 1'b1;
            adc_data <= level;
        end else begin
            adc_valid <= 1'b0;
            adc_data <= ~adc_data;
        end
    end
endmodule // afe_sensor_model
`default_nettype wire

// ### test/afe_path_checker.sv
// port assertions for the signal path mode control bank
`timescale 1ns/1ps
`default_nettype none
module afe_path_checker
    import afe_path_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data,
    input wire logic bpf_bypass,
    input wire logic int_bypass,
    input wire logic led_pulse,
    input wire logic pd_connect,
    input wire logic int_active,
    input wire logic int_negative,
    input wire logic fifo_push,
    input wire logic [15:0] fifo_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [15:0] path_a_q; // last word written to the slot a path register
    // shadow of slot a path word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) path_a_q <= RST_PATH;
        else if (reg_wr && reg_addr == OFF_SLOT_A_PATH) path_a_q <= reg_wdata;
    end
    AST_PUSH_AFTER_VALID: assert property (adc_valid |=> fifo_push)
        else $error("no push after result");
    AST_NO_SPARE_PUSH: assert property (!adc_valid |=> !fifo_push)
        else $error("push without result");
    AST_PUSH_DATA: assert property (adc_valid |=> fifo_data == $past(adc_data))
        else $error("pushed word differs from result");
    AST_INT_BYP_IMPLIES_BPF: assert property (int_bypass |-> bpf_bypass)
        else $error("integrator bypassed with filter in path");
    AST_LED_WITH_PD: assert property (led_pulse |-> pd_connect)
        else $error("led pulse without input connection");
    AST_NEG_IN_INT: assert property (int_negative |-> int_active)
        else $error("negative phase outside integration");
    AST_FLOAT_POS: assert property ($rose(int_active) |-> !pd_connect && !int_negative)
        else $error("positive phase not floating");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    AST_PATH_HELD: assert property (reg_rd && reg_addr == OFF_SLOT_A_PATH |=> reg_rdata == path_a_q)
        else $error("slot a path word not held");
    cover property (fifo_push);
    cover property (int_negative);
    cover property (led_pulse);
    cover property (int_bypass);
endmodule // afe_path_checker
bind afe_signal_path_mode_control afe_path_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_data(adc_data),
    .bpf_bypass(bpf_bypass), .int_bypass(int_bypass), .led_pulse(led_pulse),
    .pd_connect(pd_connect), .int_active(int_active), .int_negative(int_negative),
    .fifo_push(fifo_push), .fifo_data(fifo_data));
`default_nettype wire

// ### test/afe_signal_path_mode_control_tb_top.sv
// self-checking bench for the signal path mode control bank
`timescale 1ns/1ps
`default_nettype none
module afe_signal_path_mode_control_tb_top
    import afe_path_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic sample_start = 1'b0, sample_slot = 1'b0, trig = 1'b0, adc_valid;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, level = 16'h0000, adc_data, reg_rdata, fifo_data, rd_v;
    logic buf_gain_low, int_as_buf, bpf_bypass, int_bypass, led_pulse, pd_connect;
    logic int_active, int_negative, fifo_push;
    int error_cnt = 0, checks = 0, led_n, flt_n, neg_n, pd_n;
    logic [7:0] rst_a [14] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h58, 8'h14, 8'h5a, 8'h5b,
        8'h5c, 8'h5d, 8'h60, 8'h61, 8'h62, 8'h70};
    logic [15:0] rst_v [14] = '{16'h1c00, 16'hada5, 16'h1c00, 16'hada5, 16'h0000, 16'h0005,
        16'h0000, 16'h00c8, 16'h0064, 16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] path_v [3] = '{PATH_NORMAL, PATH_NO_BPF, PATH_NO_BPF_INT};
    afe_signal_path_mode_control u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_start(sample_start), .sample_slot(sample_slot), .adc_valid(adc_valid),
        .adc_data(adc_data), .buf_gain_low(buf_gain_low), .int_as_buf(int_as_buf),
        .bpf_bypass(bpf_bypass), .int_bypass(int_bypass), .led_pulse(led_pulse),
        .pd_connect(pd_connect), .int_active(int_active), .int_negative(int_negative),
        .fifo_push(fifo_push), .fifo_data(fifo_data));
    afe_sensor_model u_sensor (.sys_clk(sys_clk), .rst_b(rst_b), .trig(trig), .level(level),
        .adc_valid(adc_valid), .adc_data(adc_data));
    // 50 mhz clock
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle register read, data taken in the answer cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // wait out any running sample, start one and let the decoded controls settle
    task automatic dec(input logic s);
        repeat (12) @(posedge sys_clk);
        @(posedge sys_clk);
        sample_start <= 1'b1;
        sample_slot <= s;
        @(posedge sys_clk);
        sample_start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // wait out the last sample, start one and count switch activity from its start
    task automatic run(input logic s);
        logic seen_int, seen_pd;
        seen_int = 1'b0;
        seen_pd = 1'b0;
        led_n = 0;
        flt_n = 0;
        neg_n = 0;
        pd_n = 0;
        repeat (12) @(posedge sys_clk);
        sample_start <= 1'b1;
        sample_slot <= s;
        repeat (600) begin
            @(posedge sys_clk);
            sample_start <= 1'b0;
            #1;
            if (int_active === 1'b1) seen_int = 1'b1;
            if (led_pulse === 1'b1) led_n++;
            if (int_negative === 1'b1) neg_n++;
            if (pd_connect === 1'b1) pd_n++;
            // float time: input open after precondition, before integration
            if (pd_connect === 1'b0 && seen_pd && !seen_int) flt_n++;
            if (pd_connect === 1'b1) seen_pd = 1'b1;
        end
        rd(OFF_STATUS, rd_v);
        check(rd_v & 16'h0001, 16'h0000);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            rd(rst_a[i], rd_v);
            check(rd_v, rst_v[i]);
        end
        wr(OFF_DATA_A, 16'h1234);
        wr(8'h70, 16'h4321);
        rd(OFF_DATA_A, rd_v);
        check(rd_v, 16'h0000);
        rd(8'h70, rd_v);
        check(rd_v, 16'h0000);
        wr(OFF_PULSE_WIDTH, 16'h000a);
        wr(OFF_PHASE_LEN, 16'h0005);
        wr(OFF_SLOT_B_SETUP, 16'h1c20);
        for (int g = 0; g < 4; g++) begin
            wr(OFF_SLOT_A_SETUP, 16'h1c00 | 16'(g << 8));
            dec(1'b0);
            check(16'(buf_gain_low), 16'(g == 2));
            dec(1'b1);
            check(16'(buf_gain_low), 16'h0000);
        end
        wr(OFF_SLOT_A_SETUP, 16'h1c80);
        dec(1'b0);
        check(16'(int_as_buf), 16'h0000);
        wr(OFF_GLOBAL_EN, 16'h0080);
        dec(1'b0);
        check(16'(int_as_buf), 16'h0001);
        wr(OFF_SLOT_A_SETUP, 16'h1c00);
        dec(1'b0);
        check(16'(int_as_buf), 16'h0000);
        for (int p = 0; p < 3; p++) begin
            wr(OFF_SLOT_A_PATH, path_v[p]);
            rd(OFF_SLOT_A_PATH, rd_v);
            check(rd_v, path_v[p]);
            dec(1'b0);
            check(16'(bpf_bypass), 16'(p != 0));
            check(16'(int_bypass), 16'(p == 2));
            dec(1'b1);
            check(16'({bpf_bypass, int_bypass}), 16'h0000);
        end
        wr(OFF_SLOT_A_PATH, PATH_NORMAL);
        run(1'b0);
        check(16'(led_n), 16'h000a);
        check(16'(pd_n), 16'd600);
        wr(OFF_LED_SELECT, 16'h0004);
        run(1'b0);
        check(16'(led_n), 16'h0000);
        check(16'(pd_n), 16'h000a);
        wr(OFF_LED_SELECT, RST_LED_SELECT);
        wr(OFF_SLOT_A_PATH, PATH_NO_BPF_INT);
        wr(OFF_FLOAT_CTRL, 16'h0001);
        wr(OFF_FLOAT_TIME, 16'h00fa);
        run(1'b0);
        check(16'(flt_n), 16'h00fa);
        check(16'(neg_n), 16'h0005);
        check(16'({bpf_bypass, int_bypass}), 16'h0002);
        wr(OFF_FLOAT_CTRL, RST_FLOAT_CTRL);
        wr(OFF_SLOT_A_PATH, PATH_NORMAL);
        for (int s = 0; s < 2; s++) begin
            run(1'(s));
            @(posedge sys_clk);
            trig <= 1'b1;
            level <= 16'h5a3c ^ 16'(s * 16'h9999);
            @(posedge sys_clk);
            trig <= 1'b0;
            @(posedge sys_clk);
            #1;
            check(16'({fifo_push}), 16'h0001);
            check(fifo_data, level);
            rd(s ? OFF_DATA_B : OFF_DATA_A, rd_v);
            check(rd_v, level);
        end
        close_out();
    end
endmodule // afe_signal_path_mode_control_tb_top
`default_nettype wire
